/* hw/mct_core.sv */
`timescale 1ns/1ps
// Function
// - Keeps counting during halt while run enabled.
// - Stop freezes everything; state kept, then resumes.
// - Run enable cleared gates whole timer.
// - Channel enable gates only that channel.
// - Registers accessible while enables are cleared.
// - Count high/low bytes show live count.
// - Clearing run enable keeps count bytes.
// - Stopped: reload write lands next cycle.
// - Running: reload buffered until cycle end.
// - High byte held, low byte commits both.
// - Modulo period prescale times reload plus one.
// - Up/down period two times prescale times reload.
// - Windows access subregister chosen by subaddress.
// - Running prescale writes applied at cycle end.
// - Control zero at subaddress zero, window zero.
// - Done flag sets on cycle end; W1C; run-clear.
// - One-shot channel interrupt disables channel, drops DMA.
module mct_core
  import mct_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [CHANNELS-1:0] ch_match,
  input wire logic [CHANNELS-1:0] ch_one_shot,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [CHANNELS-1:0] ch_dma_req,
  output logic irq
);

  // Register state.
  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic [15:0] reload_buf_q;
  logic reload_pend_q;
  logic [7:0] reload_hold_q;
  logic [7:0] subaddr_q;
  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [2:0] prescale_field_buf_q;
  logic prescale_field_pend_q;
  logic run_q;
  logic [CHANNELS-1:0] ch_en_q;
  logic [CHANNELS:0] irq_stat_q;
  logic [CHANNELS:0] irq_en_q;
  logic [7:0] prescale_field_cnt_q;
  mct_dir_e dir_q;

  // Bus capture.
  mct_wreq_s wreq_q;
  logic aw_have_q;
  logic w_have_q;

  logic wr_fire;
  logic [15:0] wr_idx;
  logic [7:0] wr_byte;
  logic [15:0] rd_idx;
  logic rd_ok;
  logic [7:0] rd_byte;
  logic [7:0] sub_rd;
  logic tick;
  logic cycle_end;
  logic [7:0] prescale_field_limit;
  logic [CHANNELS-1:0] ch_irq;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_idx = 16'(wreq_q.addr >> 2);
  assign wr_byte = wreq_q.strb[0] ? wreq_q.data[7:0] : RESET_BYTE;
  assign rd_idx = 16'(s_axi_araddr >> 2);

  // Prescale divides the system clock by 2^exponent.
  assign prescale_field_limit = 8'((9'h001 << ctl1_q[C1_PRESCALE_FIELD_LSB +: 3]) - 9'h001);
  // Clock gating is modelled as an enable; a stopped system clock is clk_en low.
  assign tick = clk_en && run_q && (prescale_field_cnt_q == prescale_field_limit);

  // Modulo ends at reload (reload+1 ticks); up/down ends at zero on the way down.
  always_comb begin
    if (!tick) begin
      cycle_end = 1'b0;
    end else if (ctl1_q[C1_UPDOWN]) begin
      cycle_end = (dir_q == DIR_DOWN) && (count_q == 16'h0001);
    end else begin
      cycle_end = (count_q == reload_q);
    end
  end

  // Channel events come from the compare logic and only count while that
  // channel's clock is on.
  assign ch_irq = ch_match & ch_en_q & {CHANNELS{clk_en && run_q}};

  // AXI write channel capture; address and data are taken in either order.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wreq_q <= '0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        wreq_q.addr <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wreq_q.data <= s_axi_wdata;
        wreq_q.strb <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_idx == IDX_COUNT_HIGH || wr_idx == IDX_COUNT_LOW ||
                        wr_idx == IDX_RELOAD_HIGH || wr_idx == IDX_RELOAD_LOW ||
                        wr_idx == IDX_SUBADDR || wr_idx == IDX_WINDOW_0 ||
                        wr_idx == IDX_WINDOW_1 || wr_idx == IDX_WINDOW_2 ||
                        wr_idx == IDX_GLOBAL || wr_idx == IDX_IRQ_CLEAR ||
                        wr_idx == IDX_IRQ_ENABLE || wr_idx == IDX_IRQ_STATUS)
                       ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Subregister read mux behind the windows.
  always_comb begin
    if (subaddr_q == SUB_CONTROL_ZERO) begin
      sub_rd = ctl0_q;
    end else if (subaddr_q == SUB_CONTROL_ONE) begin
      sub_rd = ctl1_q;
    end else begin
      sub_rd = RESET_BYTE;
    end
  end

  // Register reads do not depend on run or channel enables.
  always_comb begin
    rd_ok = 1'b1;
    if (rd_idx == IDX_COUNT_HIGH) begin
      rd_byte = count_q[15:8];
    end else if (rd_idx == IDX_COUNT_LOW) begin
      rd_byte = count_q[7:0];
    end else if (rd_idx == IDX_RELOAD_HIGH) begin
      rd_byte = reload_q[15:8];
    end else if (rd_idx == IDX_RELOAD_LOW) begin
      rd_byte = reload_q[7:0];
    end else if (rd_idx == IDX_SUBADDR) begin
      rd_byte = subaddr_q;
    end else if (rd_idx == IDX_WINDOW_0 || rd_idx == IDX_WINDOW_1 || rd_idx == IDX_WINDOW_2) begin
      rd_byte = sub_rd;
    end else if (rd_idx == IDX_GLOBAL) begin
      rd_byte = 8'({ch_en_q, run_q});
    end else if (rd_idx == IDX_IRQ_STATUS) begin
      rd_byte = 8'(irq_stat_q);
    end else if (rd_idx == IDX_IRQ_ENABLE) begin
      rd_byte = 8'(irq_en_q);
    end else begin
      rd_byte = RESET_BYTE;
      rd_ok = (rd_idx == IDX_IRQ_CLEAR);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Global enables and subaddress; all state freezes when clk_en is low.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= 1'b0;
      subaddr_q <= RESET_BYTE;
    end else if (clk_en) begin
      if (wr_fire && wr_idx == IDX_GLOBAL) begin
        run_q <= wr_byte[GL_RUN];
      end
      if (wr_fire && wr_idx == IDX_SUBADDR) begin
        subaddr_q <= wr_byte;
      end
    end
  end

  // Channel enables; a one-shot channel turns itself off on its interrupt.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ch_en_q <= '0;
    end else if (clk_en) begin
      if (wr_fire && wr_idx == IDX_GLOBAL) begin
        ch_en_q <= wr_byte[GL_CH_LSB +: CHANNELS];
      end else begin
        ch_en_q <= ch_en_q & ~(ch_irq & ch_one_shot);
      end
    end
  end

  // A DMA request is only held by an enabled channel that has matched.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ch_dma_req <= '0;
    end else if (clk_en) begin
      ch_dma_req <= (ch_dma_req | ch_irq) & ch_en_q & ~(ch_irq & ch_one_shot);
    end
  end

  // Prescaler and counter.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prescale_field_cnt_q <= RESET_BYTE;
      count_q <= 16'h0000;
      dir_q <= DIR_IDLE;
    end else if (clk_en) begin
      if (wr_fire && wr_idx == IDX_COUNT_HIGH) begin
        count_q[15:8] <= wr_byte;
      end else if (wr_fire && wr_idx == IDX_COUNT_LOW) begin
        count_q[7:0] <= wr_byte;
      end else if (tick) begin
        if (ctl1_q[C1_UPDOWN]) begin
          if (dir_q == DIR_DOWN && count_q <= 16'h0001) begin
            count_q <= 16'h0000;
            dir_q <= DIR_UP;
          end else if (dir_q == DIR_DOWN) begin
            count_q <= count_q - 16'h0001;
          end else if (count_q >= reload_q - 16'h0001) begin
            count_q <= reload_q;
            dir_q <= DIR_DOWN;
          end else begin
            count_q <= count_q + 16'h0001;
            dir_q <= DIR_UP;
          end
        end else if (cycle_end) begin
          count_q <= 16'h0000;
          dir_q <= DIR_UP;
        end else begin
          count_q <= count_q + 16'h0001;
          dir_q <= DIR_UP;
        end
      end
      // The count stays put when run is cleared; only the prescaler restarts.
      if (!run_q || tick) begin
        prescale_field_cnt_q <= RESET_BYTE;
      end else begin
        prescale_field_cnt_q <= prescale_field_cnt_q + 8'h01;
      end
    end
  end

  // Reload: high byte held, low byte commits; buffered while running.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reload_q <= 16'h0000;
      reload_buf_q <= 16'h0000;
      reload_pend_q <= 1'b0;
      reload_hold_q <= RESET_BYTE;
    end else if (clk_en) begin
      if (wr_fire && wr_idx == IDX_RELOAD_HIGH) begin
        reload_hold_q <= wr_byte;
      end
      if (wr_fire && wr_idx == IDX_RELOAD_LOW && !run_q) begin
        reload_q <= {reload_hold_q, wr_byte};
        reload_pend_q <= 1'b0;
      end else if (wr_fire && wr_idx == IDX_RELOAD_LOW) begin
        reload_buf_q <= {reload_hold_q, wr_byte};
        reload_pend_q <= 1'b1;
      end else if (cycle_end && reload_pend_q) begin
        reload_q <= reload_buf_q;
        reload_pend_q <= 1'b0;
      end
    end
  end

  // Control zero and one through the windows.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctl0_q <= RESET_BYTE;
      ctl1_q <= RESET_BYTE;
      prescale_field_buf_q <= 3'b000;
      prescale_field_pend_q <= 1'b0;
    end else if (clk_en) begin
      ctl0_q[CZ_CHANNEL_STATUS_FLAG] <= |ch_en_q;
      // A window write on the same edge must not hold back a pending prescale.
      if (cycle_end && prescale_field_pend_q) begin
        ctl1_q[C1_PRESCALE_FIELD_LSB +: 3] <= prescale_field_buf_q;
        prescale_field_pend_q <= 1'b0;
      end
      if (wr_fire && (wr_idx == IDX_WINDOW_0 || wr_idx == IDX_WINDOW_1 ||
                      wr_idx == IDX_WINDOW_2)) begin
        if (subaddr_q == SUB_CONTROL_ZERO) begin
          ctl0_q[CZ_IRQEN] <= wr_byte[CZ_IRQEN];
          ctl0_q[2:0] <= wr_byte[2:0];
        end else if (subaddr_q == SUB_CONTROL_ONE) begin
          ctl1_q[C1_UPDOWN] <= wr_byte[C1_UPDOWN];
          if (run_q) begin
            prescale_field_buf_q <= wr_byte[C1_PRESCALE_FIELD_LSB +: 3];
            prescale_field_pend_q <= 1'b1;
          end else begin
            ctl1_q[C1_PRESCALE_FIELD_LSB +: 3] <= wr_byte[C1_PRESCALE_FIELD_LSB +: 3];
          end
        end
      end
      // Set wins over the write-one clear; run clear always clears.
      if (!run_q) begin
        ctl0_q[CZ_DONE] <= 1'b0;
      end else if (cycle_end) begin
        ctl0_q[CZ_DONE] <= 1'b1;
      end else if (wr_fire && wr_idx == IDX_WINDOW_0 && subaddr_q == SUB_CONTROL_ZERO &&
                   wr_byte[CZ_DONE]) begin
        ctl0_q[CZ_DONE] <= 1'b0;
      end
    end
  end

  // Interrupt status, clear and enable.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (wr_fire && wr_idx == IDX_IRQ_ENABLE) begin
        irq_en_q <= wr_byte[CHANNELS:0];
      end
      irq_stat_q <= (irq_stat_q &
                     ~((wr_fire && wr_idx == IDX_IRQ_CLEAR) ? wr_byte[CHANNELS:0] : '0))
                    | {ch_irq, cycle_end && ctl0_q[CZ_IRQEN]};
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

endmodule

/* hw/mct_pkg.sv */
package mct_pkg;

  // Register indices; the printed offsets are not all multiples of four,
  // so each printed offset is an index and the byte address is four times it.
  localparam logic [15:0] IDX_COUNT_HIGH = 16'h0FA0;
  localparam logic [15:0] IDX_COUNT_LOW = 16'h0FA1;
  localparam logic [15:0] IDX_RELOAD_HIGH = 16'h0FA2;
  localparam logic [15:0] IDX_RELOAD_LOW = 16'h0FA3;
  localparam logic [15:0] IDX_SUBADDR = 16'h0FA4;
  localparam logic [15:0] IDX_WINDOW_0 = 16'h0FA5;
  localparam logic [15:0] IDX_WINDOW_1 = 16'hFFA6;
  localparam logic [15:0] IDX_WINDOW_2 = 16'hFFA7;
  localparam logic [15:0] IDX_GLOBAL = 16'h0FA8;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h0FA9;
  localparam logic [15:0] IDX_IRQ_CLEAR = 16'h0FAA;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'h0FAB;
  localparam int ADDR_W = 18;

  // Subaddresses reached through the windows.
  localparam logic [7:0] SUB_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] SUB_CONTROL_ONE = 8'h01;

  // Control zero layout.
  localparam int CZ_DONE = 7;
  localparam int CZ_CHANNEL_STATUS_FLAG = 6;
  localparam int CZ_IRQEN = 5;
  localparam logic [7:0] CZ_WRITE_MASK = 8'h27;
  // Control one layout: prescale exponent in 6:4, up/down in 0.
  localparam int C1_PRESCALE_FIELD_LSB = 4;
  localparam int C1_UPDOWN = 0;
  localparam logic [7:0] C1_WRITE_MASK = 8'h71;
  // Global register: bit 0 run enable, bits 4:1 channel clock enables.
  localparam int GL_RUN = 0;
  localparam int GL_CH_LSB = 1;
  // Interrupt status bits.
  localparam int IRQ_CYCLE = 0;
  localparam int IRQ_CH_LSB = 1;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } mct_wreq_s;

  typedef enum logic [2:0] {
    DIR_UP = 3'b001,
    DIR_DOWN = 3'b010,
    DIR_IDLE = 3'b100
  } mct_dir_e;

endpackage

/* verification/mct_core_asserts.sv */
`timescale 1ns/1ps
module mct_core_asserts
  import mct_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [CHANNELS-1:0] ch_match,
  input wire logic [CHANNELS-1:0] ch_one_shot,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CHANNELS-1:0] ch_dma_req,
  input wire logic irq
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready && clk_en |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rdata_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
  busy_refuse_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  stop_freeze_a: assert property (
    !clk_en |=> $stable({ch_dma_req, irq, s_axi_bvalid, s_axi_rvalid}))
    else $error("state moved while stopped");
  dma_cause_a: assert property (
    (ch_dma_req & ~$past(ch_dma_req) & ~$past(ch_match)) == '0)
    else $error("dma request without match");
  one_shot_drop_a: assert property (
    clk_en && |(ch_match & ch_one_shot) |=>
    ((ch_dma_req & $past(ch_match & ch_one_shot)) == '0))
    else $error("one-shot dma request kept");
endmodule

bind mct_core mct_core_asserts #(.CHANNELS(CHANNELS)) u_chk (.ref_clk, .resetn, .clk_en,
  .ch_match, .ch_one_shot, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ch_dma_req, .irq);

/* verification/mct_core_tb.sv */
`timescale 1ns/1ps
module mct_core_tb
  import mct_pkg::*;
;
  logic ref_clk, resetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [3:0] ch_match, ch_one_shot, s_axi_wstrb, ch_dma_req;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] d;
  int err_total, n_compared, cyc, t0, t1;

  mct_core dut (.ref_clk, .resetn, .clk_en, .ch_match, .ch_one_shot, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ch_dma_req, .irq);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // The ceiling is far above the few hundred cycles the sequence needs.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out;
    end
  end

  task automatic cmp(input logic [31:0] a, input logic [31:0] e);
    n_compared++;
    if (a !== e) begin
      err_total++;
      $display("[FAIL] %0t got %0h expected %0h", $time, a, e);
    end
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] v);
    @(posedge ref_clk);
    s_axi_awaddr <= ADDR_W'({i, 2'b00});
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] i, output logic [7:0] v, output logic [1:0] rr);
    @(posedge ref_clk);
    s_axi_araddr <= ADDR_W'({i, 2'b00});
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata[7:0];
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk(input logic [15:0] i, input logic [7:0] e);
    rd(i, d, r);
    cmp({r, d}, {RESP_OKAY, e});
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge ref_clk);
    ch_match <= m;
    @(posedge ref_clk);
    ch_match <= 4'h0;
    #1;
  endtask

  // Clears the cycle event, then returns the cycle count at the next irq rise.
  // The short wait lets the registered irq fall before watching for the rise.
  task automatic rise(output int t);
    wr(IDX_IRQ_CLEAR, 8'h01);
    repeat (3) @(posedge ref_clk);
    while (!irq) @(posedge ref_clk);
    t = cyc;
  endtask

  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {ch_match, ch_one_shot, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {err_total, n_compared, cyc} = '0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'h1;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(16'h0000, d, r);
    cmp({r, d}, {RESP_SLVERR, 8'h00});
    wr(16'h0000, 8'h00);
    cmp(r, RESP_SLVERR);
    chk(IDX_COUNT_HIGH, 8'h00);
    chk(IDX_COUNT_LOW, 8'h00);
    chk(IDX_RELOAD_LOW, 8'h00);
    chk(IDX_WINDOW_0, 8'h00);
    wr(IDX_RELOAD_HIGH, 8'h12);
    wr(IDX_RELOAD_LOW, 8'h34);
    cmp(r, RESP_OKAY);
    chk(IDX_RELOAD_HIGH, 8'h12);
    chk(IDX_RELOAD_LOW, 8'h34);
    wr(IDX_RELOAD_HIGH, 8'h00);
    wr(IDX_RELOAD_LOW, 8'h05);
    wr(IDX_SUBADDR, SUB_CONTROL_ONE);
    wr(IDX_WINDOW_1, 8'h10);
    chk(IDX_WINDOW_2, 8'h10);
    wr(IDX_SUBADDR, SUB_CONTROL_ZERO);
    wr(IDX_WINDOW_0, 8'hF8);
    chk(IDX_WINDOW_0, 8'h20);
    wr(IDX_IRQ_ENABLE, 8'h01);
    wr(IDX_GLOBAL, 8'h01);
    rise(t0);
    rise(t1);
    cmp(t1 - t0, 12);
    chk(IDX_WINDOW_0, 8'hA0);
    wr(IDX_RELOAD_LOW, 8'h09);
    wr(IDX_SUBADDR, SUB_CONTROL_ONE);
    wr(IDX_WINDOW_0, 8'h21);
    wr(IDX_SUBADDR, SUB_CONTROL_ZERO);
    rise(t0);
    rise(t0);
    rise(t1);
    cmp(t1 - t0, 72);
    wr(IDX_WINDOW_0, 8'hA0);
    chk(IDX_WINDOW_0, 8'h20);
    wr(IDX_IRQ_ENABLE, 8'h00);
    wr(IDX_GLOBAL, 8'h03);
    wr(IDX_IRQ_CLEAR, 8'hFF);
    pulse(4'h3);
    cmp(ch_dma_req, 4'h1);
    rd(IDX_IRQ_STATUS, d, r);
    cmp(d & 8'h1E, 8'h02);
    cmp(irq, 1'b0);
    wr(IDX_IRQ_ENABLE, 8'h02);
    @(posedge ref_clk);
    #1 cmp(irq, 1'b1);
    wr(IDX_IRQ_CLEAR, 8'h02);
    @(posedge ref_clk);
    #1 cmp(irq, 1'b0);
    chk(IDX_IRQ_CLEAR, 8'h00);
    ch_one_shot <= 4'h4;
    wr(IDX_GLOBAL, 8'h09);
    pulse(4'h4);
    repeat (3) @(posedge ref_clk);
    cmp(ch_dma_req[2], 1'b0);
    chk(IDX_GLOBAL, 8'h01);
    clk_en <= 1'b0;
    repeat (20) @(posedge ref_clk);
    clk_en <= 1'b1;
    chk(IDX_RELOAD_LOW, 8'h09);
    wr(IDX_GLOBAL, 8'h02);
    chk(IDX_WINDOW_0, 8'h60);
    pulse(4'h1);
    cmp(ch_dma_req, 4'h0);
    wr(IDX_COUNT_HIGH, 8'hAB);
    wr(IDX_COUNT_LOW, 8'hCD);
    repeat (30) @(posedge ref_clk);
    chk(IDX_COUNT_HIGH, 8'hAB);
    chk(IDX_COUNT_LOW, 8'hCD);
    close_out;
  end
endmodule
